// ===== ucti_defs.vh
// constants for the uart counter/timer and interrupt status block
`ifndef UCTI_DEFS_VH
`define UCTI_DEFS_VH
// register offsets on the four-bit host address
`define UCTI_OFS_AUX_CTRL 4'h4
`define UCTI_OFS_INT_STATUS 4'h5
`define UCTI_OFS_PRESET_UPPER 4'h6
`define UCTI_OFS_PRESET_LOWER 4'h7
`define UCTI_OFS_VECTOR 4'hc
`define UCTI_OFS_START 4'he
`define UCTI_OFS_STOP 4'hf
// interrupt status bit positions
`define UCTI_BIT_INPUT_CHANGE 7
`define UCTI_BIT_COUNTER_READY 3
`define UCTI_BIT_BREAK_CHANGE 2
`define UCTI_BIT_RX_INT 1
`define UCTI_BIT_TX_INT 0
// auxiliary control fields
`define UCTI_AUX_MODE_HI 6
`define UCTI_AUX_MODE_LO 4
`define UCTI_AUX_EN_HI 3
`define UCTI_AUX_EN_LO 0
// counter/timer mode and clock codes
`define UCTI_MODE_CNT_PIN 3'h0
`define UCTI_MODE_CNT_TXC 3'h1
`define UCTI_MODE_RESERVED 3'h2
`define UCTI_MODE_CNT_XTAL16 3'h3
`define UCTI_MODE_TMR_PIN 3'h4
`define UCTI_MODE_TMR_PIN16 3'h5
`define UCTI_MODE_TMR_XTAL 3'h6
`define UCTI_MODE_TMR_XTAL16 3'h7
// output select code that routes the counter/timer to its pin
`define UCTI_OSEL_TIMER 2'h1
// reset values
`define UCTI_RST_STATUS 8'h00
`define UCTI_RST_MASK 8'h00
`define UCTI_RST_VECTOR 8'h0f
`define UCTI_RST_AUX 8'h00
`define UCTI_RST_PRESET 16'h0002
`define UCTI_RST_PRESET_UPPER 8'h00
`define UCTI_RST_PRESET_LOWER 8'h02
// prescale divide
`define UCTI_PRESCALE_LAST 4'hf
`endif

// ===== ucti_count_core.v
// sixteen-bit counter/timer core: square wave or count-down with terminal flag
`timescale 1ns/100ps
`include "ucti_defs.vh"
module ucti_count_core (
   input wire clock,
   input wire rst,
   input wire tick,
   input wire timer_mode,
   input wire start,
   input wire stop,
   input wire [15:0] preset,
   output reg [15:0] count_q,
   output reg wave_q,
   output reg ready_q
);
   reg running_q;
   wire at_zero = (count_q == 16'h0001);

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         count_q <= 16'h0000;
         wave_q <= 1'b1;
         ready_q <= 1'b0;
         running_q <= 1'b0;
      end else begin
         ready_q <= 1'b0;
         if (start) begin
            // restart abandons the cycle in progress
            running_q <= 1'b1;
            count_q <= preset;
            wave_q <= 1'b1;
         end else if (stop && !timer_mode) begin
            running_q <= 1'b0;
            wave_q <= 1'b1;
         end else if (running_q && tick) begin
            if (timer_mode) begin
               if (at_zero) begin
                  // fresh preset only at a half-period boundary
                  count_q <= preset;
                  wave_q <= ~wave_q;
                  ready_q <= ~wave_q; // once per full cycle
               end else begin
                  count_q <= count_q - 16'h0001;
               end
            end else begin
               // keeps counting past zero, wrapping
               count_q <= count_q - 16'h0001;
               if (at_zero) begin
                  ready_q <= 1'b1;
                  wave_q <= 1'b0;
               end
            end
         end
      end
   end
endmodule // ucti_count_core

// ===== ucti_timer_int.v
// host bus, interrupt status/mask/vector and counter/timer control
//
// Contract
// - request low when masked status bit set
// - status reads ignore the mask
// - reset clears interrupt status to zero
// - fixed status bit layout, bits 6-4 reserved
// - input change set by enabled pin change
// - break change cleared only by command
// - transmit bit follows transmit level interrupt
// - mask gates only the common request
// - vector resets 0x0f, driven on acknowledge
// - outside 68k mode vector is scratch byte
// - write-only 16-bit preset, minimum two
// - timer period twice preset value
// - idle until start read at 1110
// - start restarts cycle with current preset
// - timer preset change waits half-period
// - ready once per cycle, stop clears it
// - counter counts down, flags zero, continues
// - counter pin high until terminal count
// - counter preset used only at start
// - live count readable as two bytes
// - three-bit field selects mode and clock
// - open-drain timer pin when selected
`timescale 1ns/100ps
`include "ucti_defs.vh"
module ucti_timer_int (
   input wire clock,
   input wire rst,
   input wire chip_select_n,
   input wire read_n,
   input wire write_n,
   input wire [3:0] address,
   input wire [7:0] data_in,
   output reg [7:0] data_out_q,
   output reg data_oe_q,
   input wire interrupt_acknowledge_n,
   input wire bus_mode_68k,
   output reg interrupt_request_n_q,
   input wire [3:0] input_pins,
   input wire tx_clock_tick,
   input wire break_edge,
   input wire break_change_reset,
   input wire receive_level_interrupt,
   input wire transmit_level_interrupt,
   input wire [1:0] output_select_control,
   input wire timer_pin_port_level,
   output reg timer_output_pin_o_q,
   output reg timer_output_pin_oe_q
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: the bus lines and the four input pins pass two flops
   reg [17:0] bus_s1_q;
   reg [17:0] bus_s2_q;
   reg [3:0] pin_s1_q;
   reg [3:0] pin_s2_q;
   reg [3:0] pin_prev_q;
   reg pin_seen_q;
   wire [17:0] bus_raw = {bus_mode_68k, interrupt_acknowledge_n, chip_select_n, read_n, write_n,
                          address, data_in, 1'b0};

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         // idle levels: strobes and acknowledge high, so no false edge after reset
         bus_s1_q <= 18'h1fff8;
         bus_s2_q <= 18'h1fff8;
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
         pin_prev_q <= 4'h0;
         pin_seen_q <= 1'b0;
      end else begin
         bus_s1_q <= bus_raw;
         bus_s2_q <= bus_s1_q;
         pin_s1_q <= input_pins;
         pin_s2_q <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
         pin_seen_q <= 1'b1;
      end
   end

   wire mode_68k = bus_s2_q[17];
   wire ack_low = ~bus_s2_q[16];
   wire rd_act = ~bus_s2_q[15] & ~bus_s2_q[14];
   wire wr_act = ~bus_s2_q[15] & ~bus_s2_q[13];
   wire [3:0] addr_s = bus_s2_q[12:9];
   wire [7:0] wdata_s = bus_s2_q[8:1];

   ////////////////////////////////////////////////////////////////////////////
   // strobe edge detection: one action per bus cycle
   reg rd_prev_q;
   reg wr_prev_q;
   reg ack_prev_q;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
         ack_prev_q <= 1'b0;
      end else begin
         rd_prev_q <= rd_act;
         wr_prev_q <= wr_act;
         ack_prev_q <= ack_low;
      end
   end
   wire rd_go = rd_act & ~rd_prev_q;
   // writes take effect at the trailing edge, when address and data have settled
   wire wr_go = ~wr_act & wr_prev_q;
   reg [3:0] wr_addr_q;
   reg [7:0] wr_data_q;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_addr_q <= 4'h0;
         wr_data_q <= 8'h00;
      end else if (wr_act) begin
         wr_addr_q <= addr_s;
         wr_data_q <= wdata_s;
      end
   end

   wire cmd_start = rd_go && (addr_s == `UCTI_OFS_START);
   wire cmd_stop = rd_go && (addr_s == `UCTI_OFS_STOP);
   wire rd_change = rd_go && (addr_s == `UCTI_OFS_AUX_CTRL);

   ////////////////////////////////////////////////////////////////////////////
   // write-only and read/write registers
   reg [7:0] aux_control_q;
   reg [7:0] interrupt_mask_q;
   reg [7:0] timer_preset_upper_q;
   reg [7:0] timer_preset_lower_q;
   reg [7:0] vector_or_scratch_q;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         aux_control_q <= `UCTI_RST_AUX;
         interrupt_mask_q <= `UCTI_RST_MASK;
         timer_preset_upper_q <= `UCTI_RST_PRESET_UPPER;
         timer_preset_lower_q <= `UCTI_RST_PRESET_LOWER;
         vector_or_scratch_q <= `UCTI_RST_VECTOR;
      end else if (wr_go) begin
         case (wr_addr_q)
            `UCTI_OFS_AUX_CTRL: aux_control_q <= wr_data_q;
            `UCTI_OFS_INT_STATUS: interrupt_mask_q <= wr_data_q;
            // host keeps the preset at two or more
            `UCTI_OFS_PRESET_UPPER: timer_preset_upper_q <= wr_data_q;
            `UCTI_OFS_PRESET_LOWER: timer_preset_lower_q <= wr_data_q;
            `UCTI_OFS_VECTOR: vector_or_scratch_q <= wr_data_q;
            default: aux_control_q <= aux_control_q;
         endcase
      end
   end
   wire [2:0] ct_mode = aux_control_q[`UCTI_AUX_MODE_HI:`UCTI_AUX_MODE_LO];
   wire [3:0] change_en = aux_control_q[`UCTI_AUX_EN_HI:`UCTI_AUX_EN_LO];

   ////////////////////////////////////////////////////////////////////////////
   // input change register: deltas latch until the host reads it
   reg [3:0] delta_q;
   wire [3:0] pin_changed = (pin_s2_q ^ pin_prev_q) & {4{pin_seen_q}};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_delta
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               delta_q[gi] <= 1'b0;
            end else if (pin_changed[gi]) begin
               delta_q[gi] <= 1'b1; // new change beats the clearing read
            end else if (rd_change) begin
               delta_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // counter/timer clock selection
   reg ip2_prev_q;
   reg [3:0] prescale_q;
   reg base_tick;
   reg divide16;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ip2_prev_q <= 1'b0;
      end else begin
         ip2_prev_q <= pin_s2_q[2];
      end
   end
   wire ip2_rise = pin_s2_q[2] & ~ip2_prev_q & pin_seen_q;

   always @* begin
      base_tick = 1'b0;
      divide16 = 1'b0;
      case (ct_mode)
         `UCTI_MODE_CNT_PIN: base_tick = ip2_rise;
         `UCTI_MODE_CNT_TXC: base_tick = tx_clock_tick;
         `UCTI_MODE_CNT_XTAL16: begin
            base_tick = 1'b1;
            divide16 = 1'b1;
         end
         `UCTI_MODE_TMR_PIN: base_tick = ip2_rise;
         `UCTI_MODE_TMR_PIN16: begin
            base_tick = ip2_rise;
            divide16 = 1'b1;
         end
         `UCTI_MODE_TMR_XTAL: base_tick = 1'b1;
         `UCTI_MODE_TMR_XTAL16: begin
            base_tick = 1'b1;
            divide16 = 1'b1;
         end
         default: base_tick = 1'b0; // reserved code: clock stands still
      endcase
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         prescale_q <= 4'h0;
      end else if (cmd_start) begin
         prescale_q <= 4'h0;
      end else if (base_tick) begin
         prescale_q <= prescale_q + 4'h1;
      end
   end
   wire ct_tick = base_tick && (!divide16 || prescale_q == `UCTI_PRESCALE_LAST);
   wire timer_mode = ct_mode[2];

   wire [15:0] live_count;
   wire ct_wave;
   wire ct_ready;
   ucti_count_core ucti_count_core_inst (
      .clock(clock),
      .rst(rst),
      .tick(ct_tick),
      .timer_mode(timer_mode),
      .start(cmd_start),
      .stop(cmd_stop),
      .preset({timer_preset_upper_q, timer_preset_lower_q}),
      .count_q(live_count),
      .wave_q(ct_wave),
      .ready_q(ct_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status: hardware set wins over any clear
   reg change_q;
   reg counter_ready_q;
   reg break_q;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         change_q <= 1'b0;
         counter_ready_q <= 1'b0;
         break_q <= 1'b0;
      end else begin
         if (|(pin_changed & change_en)) begin
            change_q <= 1'b1;
         end else if (rd_change) begin
            change_q <= 1'b0;
         end
         if (ct_ready) begin
            counter_ready_q <= 1'b1;
         end else if (cmd_stop) begin
            counter_ready_q <= 1'b0;
         end
         if (break_edge) begin
            break_q <= 1'b1;
         end else if (break_change_reset) begin
            break_q <= 1'b0;
         end
      end
   end

   // rx and tx bits are live levels from their own engines
   wire [7:0] int_status = {change_q, 3'h0, counter_ready_q, break_q,
                            receive_level_interrupt, transmit_level_interrupt};

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         interrupt_request_n_q <= 1'b1;
      end else begin
         // released as soon as no masked source remains
         interrupt_request_n_q <= ~|(int_status & interrupt_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timer output pin: open drain when routed, never masked
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         timer_output_pin_o_q <= 1'b0;
         timer_output_pin_oe_q <= 1'b0;
      end else if (output_select_control == `UCTI_OSEL_TIMER) begin
         timer_output_pin_o_q <= 1'b0;
         timer_output_pin_oe_q <= ~ct_wave;
      end else begin
         timer_output_pin_o_q <= timer_pin_port_level;
         timer_output_pin_oe_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data: captured at the start of each read, held while it lasts
   wire ack_go = ack_low & ~ack_prev_q & mode_68k;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         data_out_q <= 8'h00;
         data_oe_q <= 1'b0;
      end else begin
         data_oe_q <= rd_act | (ack_low & mode_68k);
         if (ack_go) begin
            data_out_q <= vector_or_scratch_q;
         end else if (rd_go) begin
            case (addr_s)
               `UCTI_OFS_AUX_CTRL: data_out_q <= {delta_q, pin_s2_q};
               `UCTI_OFS_INT_STATUS: data_out_q <= int_status;
               // live count, stop a counter first to avoid a carry between bytes; stop does not halt the timer
               `UCTI_OFS_PRESET_UPPER: data_out_q <= live_count[15:8];
               `UCTI_OFS_PRESET_LOWER: data_out_q <= live_count[7:0];
               `UCTI_OFS_VECTOR: data_out_q <= vector_or_scratch_q;
               default: data_out_q <= 8'h00;
            endcase
         end
      end
   end
endmodule // ucti_timer_int

// ===== ucti_timer_int_chk.sv
// port assertions for the interrupt status and counter/timer block
`timescale 1ns/100ps
module ucti_timer_int_chk (
   input wire clock,
   input wire rst,
   input wire chip_select_n,
   input wire read_n,
   input wire [3:0] address,
   input wire [7:0] data_out_q,
   input wire data_oe_q,
   input wire interrupt_acknowledge_n,
   input wire bus_mode_68k,
   input wire interrupt_request_n_q,
   input wire [1:0] output_select_control,
   input wire timer_output_pin_o_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   a_reset_quiet: assert property ($past(rst) |-> interrupt_request_n_q && !data_oe_q)
      else $error("request or bus drive active after reset");
   a_read_drives: assert property ((!chip_select_n && !read_n) [*4] |-> data_oe_q)
      else $error("read not answered in time");
   a_cmd_zero: assert property ((!chip_select_n && !read_n && address >= 4'he) [*5]
      |-> data_out_q == 8'h00)
      else $error("start or stop read returned data");
   a_ack_drives: assert property ((bus_mode_68k && !interrupt_acknowledge_n) [*4] |-> data_oe_q)
      else $error("vector not driven on acknowledge");
   a_bus_idle: assert property ((read_n && interrupt_acknowledge_n) [*6] |-> !data_oe_q)
      else $error("bus driven while idle");
   a_ack_ignored: assert property ((!bus_mode_68k && read_n) [*6] |-> !data_oe_q)
      else $error("acknowledge honoured outside 68k mode");
   a_data_hold: assert property ((read_n && interrupt_acknowledge_n) [*4] |=> $stable(data_out_q))
      else $error("read data changed without access");
   a_od_low: assert property ((output_select_control == 2'h1) [*2] |-> !timer_output_pin_o_q)
      else $error("open-drain pin driven high");
endmodule // ucti_timer_int_chk

bind ucti_timer_int ucti_timer_int_chk ucti_timer_int_chk_inst (.clock(clock), .rst(rst),
   .chip_select_n(chip_select_n), .read_n(read_n), .address(address),
   .data_out_q(data_out_q), .data_oe_q(data_oe_q), .bus_mode_68k(bus_mode_68k),
   .interrupt_acknowledge_n(interrupt_acknowledge_n), .interrupt_request_n_q(interrupt_request_n_q),
   .output_select_control(output_select_control), .timer_output_pin_o_q(timer_output_pin_o_q));

// ===== ucti_host.sv
// host processor model on the parallel register bus
`timescale 1ns/100ps
module ucti_host (
   input wire clock,
   output reg chip_select_n = 1'b1,
   output reg read_n = 1'b1,
   output reg write_n = 1'b1,
   output reg [3:0] address = 4'h0,
   output reg [7:0] data_in = 8'h00,
   input wire [7:0] data_out_q
);
   // strobe low time; raised by the bench to act as a slow host
   integer hold_cycles = 5;
   ////////////////////////////////////////////////////////////
   // released lines show the inverse, so a stale copy is never reused
   task bus_read(input [3:0] a, output [7:0] v);
      begin
         @(posedge clock);
         chip_select_n <= 1'b0;
         read_n <= 1'b0;
         address <= a;
         repeat (hold_cycles) @(posedge clock);
         v = data_out_q;
         chip_select_n <= 1'b1;
         read_n <= 1'b1;
         address <= ~a;
         repeat (4) @(posedge clock);
      end
   endtask
   task bus_write(input [3:0] a, input [7:0] d);
      begin
         @(posedge clock);
         chip_select_n <= 1'b0;
         write_n <= 1'b0;
         address <= a;
         data_in <= d;
         repeat (hold_cycles) @(posedge clock);
         chip_select_n <= 1'b1;
         write_n <= 1'b1;
         address <= ~a;
         data_in <= ~d;
         repeat (5) @(posedge clock);
      end
   endtask
endmodule // ucti_host

// ===== ucti_timer_int_tb_top.sv
// self-checking bench for the interrupt status and counter/timer block
`timescale 1ns/100ps
module ucti_timer_int_tb_top;
   reg clock = 1'b0;
   reg rst = 1'b1;
   reg interrupt_acknowledge_n = 1'b1;
   reg bus_mode_68k = 1'b0;
   reg [3:0] input_pins = 4'h0;
   reg tx_clock_tick = 1'b0;
   reg break_edge = 1'b0;
   reg break_change_reset = 1'b0;
   reg receive_level_interrupt = 1'b0;
   reg transmit_level_interrupt = 1'b0;
   reg [1:0] output_select_control = 2'h0;
   wire chip_select_n, read_n, write_n, data_oe_q, interrupt_request_n_q;
   wire timer_output_pin_o_q, timer_output_pin_oe_q;
   wire [3:0] address;
   wire [7:0] data_in, data_out_q;
   integer error_cnt = 0;
   integer num_checks = 0;
   integer cyc = 0;
   integer per;

   ucti_host ucti_host_inst (.clock(clock), .chip_select_n(chip_select_n), .read_n(read_n),
      .write_n(write_n), .address(address), .data_in(data_in), .data_out_q(data_out_q));
   ucti_timer_int ucti_timer_int_inst (.clock(clock), .rst(rst), .chip_select_n(chip_select_n),
      .read_n(read_n), .write_n(write_n), .address(address), .data_in(data_in),
      .data_out_q(data_out_q), .data_oe_q(data_oe_q), .bus_mode_68k(bus_mode_68k),
      .interrupt_acknowledge_n(interrupt_acknowledge_n), .input_pins(input_pins),
      .interrupt_request_n_q(interrupt_request_n_q), .tx_clock_tick(tx_clock_tick),
      .break_edge(break_edge), .break_change_reset(break_change_reset),
      .receive_level_interrupt(receive_level_interrupt), .timer_pin_port_level(1'b1),
      .transmit_level_interrupt(transmit_level_interrupt),
      .output_select_control(output_select_control),
      .timer_output_pin_o_q(timer_output_pin_o_q), .timer_output_pin_oe_q(timer_output_pin_oe_q));
   ////////////////////////////////////////////////////////////
   task check(input [7:0] seen, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // mask drops the reserved status bits
   task rd(input [3:0] a, input [7:0] m, input [7:0] e);
      reg [7:0] v;
      begin
         ucti_host_inst.bus_read(a, v);
         check(v & m, e);
      end
   endtask
   task irq(input e);
      check({7'h00, interrupt_request_n_q}, {7'h00, e});
   endtask
   task pin(input e);
      check({7'h00, timer_output_pin_oe_q}, {7'h00, e});
   endtask
   task ticks(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            @(posedge clock) tx_clock_tick <= 1'b1;
            @(posedge clock) tx_clock_tick <= 1'b0;
         end
         repeat (4) @(posedge clock);
      end
   endtask
   // cycles between two pin-low starts of the square wave
   task period;
      integer k, e0;
      reg prv;
      begin
         e0 = -1;
         per = -1;
         prv = timer_output_pin_oe_q;
         for (k = 0; k < 300 && per < 0; k = k + 1) begin
            @(posedge clock);
            if (timer_output_pin_oe_q && !prv) begin
               if (e0 >= 0) per = k - e0;
               else e0 = k;
            end
            prv = timer_output_pin_oe_q;
         end
      end
   endtask
   task t_status;
      begin
         check({6'h00, timer_output_pin_o_q, timer_output_pin_oe_q}, 8'h03);
         rd(4'h5, 8'h8f, 8'h00);
         rd(4'hc, 8'hff, 8'h0f);
         @(posedge clock) receive_level_interrupt <= 1'b1;
         rd(4'h5, 8'h8f, 8'h02);
         irq(1'b1);
         ucti_host_inst.bus_write(4'h5, 8'h02);
         irq(1'b0);
         @(posedge clock) receive_level_interrupt <= 1'b0;
         @(posedge clock) transmit_level_interrupt <= 1'b1;
         repeat (4) @(posedge clock);
         irq(1'b1);
         rd(4'h5, 8'h8f, 8'h01);
         @(posedge clock) transmit_level_interrupt <= 1'b0;
         ucti_host_inst.bus_write(4'h5, 8'h04);
         @(posedge clock) break_edge <= 1'b1;
         @(posedge clock) break_edge <= 1'b0;
         rd(4'h5, 8'h8f, 8'h04);
         irq(1'b0);
         rd(4'h5, 8'h8f, 8'h04);
         @(posedge clock) break_change_reset <= 1'b1;
         @(posedge clock) break_change_reset <= 1'b0;
         rd(4'h5, 8'h8f, 8'h00);
         irq(1'b1);
         ucti_host_inst.bus_write(4'h4, 8'h01);
         @(posedge clock) input_pins <= 4'h2;
         repeat (5) @(posedge clock);
         rd(4'h5, 8'h8f, 8'h00);
         @(posedge clock) input_pins <= 4'h3;
         repeat (5) @(posedge clock);
         rd(4'h5, 8'h8f, 8'h80);
         rd(4'h4, 8'hff, 8'h33);
         rd(4'h5, 8'h8f, 8'h00);
         $display("status test done");
      end
   endtask
   task t_vector;
      begin
         ucti_host_inst.hold_cycles = 9;
         ucti_host_inst.bus_write(4'hc, 8'h5a);
         rd(4'hc, 8'hff, 8'h5a);
         ucti_host_inst.hold_cycles = 5;
         @(posedge clock) bus_mode_68k <= 1'b1;
         repeat (3) @(posedge clock);
         interrupt_acknowledge_n <= 1'b0;
         repeat (5) @(posedge clock);
         check(data_out_q, 8'h5a);
         check({7'h00, data_oe_q}, 8'h01);
         interrupt_acknowledge_n <= 1'b1;
         @(posedge clock) bus_mode_68k <= 1'b0;
         repeat (5) @(posedge clock);
         $display("vector test done");
      end
   endtask
   task t_timer;
      begin
         @(posedge clock) output_select_control <= 2'h1;
         ucti_host_inst.bus_write(4'h4, 8'h60);
         ucti_host_inst.bus_write(4'h5, 8'h08);
         ucti_host_inst.bus_write(4'h6, 8'h00);
         ucti_host_inst.bus_write(4'h7, 8'h40);
         rd(4'he, 8'hff, 8'h00);
         period;
         check(per[7:0], 8'h80);
         // ready is set as the pin is released, so the reads below race nothing
         while (timer_output_pin_oe_q) @(posedge clock);
         rd(4'h5, 8'h8f, 8'h08);
         irq(1'b0);
         rd(4'hf, 8'hff, 8'h00);
         rd(4'h5, 8'h8f, 8'h00);
         irq(1'b1);
         ucti_host_inst.bus_write(4'h5, 8'h00);
         period;
         check(per[7:0], 8'h80);
         $display("timer test done");
      end
   endtask
   // preset changed inside a half-period, then the divided crystal clock
   task t_modes;
      begin
         fork
            period;
            begin
               repeat (140) @(posedge clock);
               ucti_host_inst.bus_write(4'h7, 8'h20);
            end
         join
         check(per[7:0], 8'h60);
         check({7'h00, timer_output_pin_o_q}, 8'h00);
         ucti_host_inst.bus_write(4'h4, 8'h70);
         ucti_host_inst.bus_write(4'h7, 8'h02);
         rd(4'he, 8'hff, 8'h00);
         period;
         check(per[7:0], 8'h40);
         $display("mode test done");
      end
   endtask
   task t_counter;
      begin
         ucti_host_inst.bus_write(4'h4, 8'h10);
         rd(4'hf, 8'hff, 8'h00);
         ucti_host_inst.bus_write(4'h7, 8'h03);
         rd(4'he, 8'hff, 8'h00);
         pin(1'b0);
         ticks(2);
         pin(1'b0);
         ticks(1);
         pin(1'b1);
         rd(4'h5, 8'h8f, 8'h08);
         ticks(1);
         rd(4'hf, 8'hff, 8'h00);
         pin(1'b0);
         rd(4'h5, 8'h8f, 8'h00);
         rd(4'h6, 8'hff, 8'hff);
         rd(4'h7, 8'hff, 8'hff);
         ucti_host_inst.bus_write(4'h7, 8'h07);
         rd(4'h7, 8'hff, 8'hff);
         rd(4'he, 8'hff, 8'h00);
         rd(4'h6, 8'hff, 8'h00);
         rd(4'h7, 8'hff, 8'h07);
         // counter on rising edges of the external count input
         ucti_host_inst.bus_write(4'h4, 8'h00);
         rd(4'he, 8'hff, 8'h00);
         repeat (3) begin
            @(posedge clock) input_pins <= 4'h7;
            repeat (3) @(posedge clock);
            input_pins <= 4'h3;
            repeat (3) @(posedge clock);
         end
         rd(4'hf, 8'hff, 8'h00);
         rd(4'h7, 8'hff, 8'h04);
         $display("counter test done");
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         results;
      end
   end
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      t_status;
      t_vector;
      t_timer;
      t_modes;
      t_counter;
      results;
   end
endmodule // ucti_timer_int_tb_top
